/* hw/tfp_pkg.sv */
package tfp_pkg;

    localparam int CLK_PERIOD_NS   = 8;
    localparam int TICK_PERIOD_US  = 1000;
    localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
    // ramp times are held in units of 0.1 s = 100000 us
    localparam int TICKS_PER_DS    = 100000 / TICK_PERIOD_US;
    localparam int FRAC_BITS       = 16;

    localparam int NUM_TERMS       = 5;
    localparam logic [7:0] FUNC_TRAVERSE_EN = 8'h25;

    localparam logic [31:0] PCT_DIV = 32'h0000_0064;

    localparam logic [2:0] PIDX_MODE  = 3'h0;
    localparam logic [2:0] PIDX_AMP   = 3'h1;
    localparam logic [2:0] PIDX_DCOMP = 3'h2;
    localparam logic [2:0] PIDX_UCOMP = 3'h3;
    localparam logic [2:0] PIDX_TACC  = 3'h4;
    localparam logic [2:0] PIDX_TDEC  = 3'h5;

    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [15:0] AMP_RST   = 16'h000a;
    localparam logic [15:0] DCOMP_RST = 16'h000a;
    localparam logic [15:0] UCOMP_RST = 16'h000a;
    localparam logic [15:0] TIME_RST  = 16'h0032;
    localparam logic [15:0] TIME_MIN  = 16'h0001;
    localparam logic [15:0] TIME_MAX  = 16'h8ca0;
    localparam logic [15:0] PCT_MAX   = 16'h0064;
    localparam logic [15:0] MODE_ONE  = 16'h0001;
    localparam logic [15:0] MODE_TWO  = 16'h0002;
    localparam logic [7:0]  VIS_OPEN  = 8'h00;

    typedef enum logic [6:0] {
        S_IDLE     = 7'b000_0001,
        S_APPROACH = 7'b000_0010,
        S_BASE     = 7'b000_0100,
        S_UP       = 7'b000_1000,
        S_DOWN     = 7'b001_0000,
        S_RECENTER = 7'b010_0000,
        S_STOP     = 7'b100_0000
    } tfp_state_t;

endpackage

/* hw/tfp_param_store.sv */
`timescale 1ns/1ps
`default_nettype none
module tfp_param_store
    import tfp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  extended_param_visibility,
    input  wire logic        param_wr_en,
    input  wire logic [2:0]  param_wr_idx,
    input  wire logic [15:0] param_wr_data,
    output logic             param_wr_refused,
    output logic [15:0]      traverse_mode_select,
    output logic [15:0]      amplitude_percent,
    output logic [15:0]      down_turn_compensation,
    output logic [15:0]      up_turn_compensation,
    output logic [15:0]      traverse_accel_time,
    output logic [15:0]      traverse_decel_time
);

    logic open_wr;
    logic time_ok;
    logic pct_ok;
    logic mode_ok;

    assign open_wr = param_wr_en && (extended_param_visibility == VIS_OPEN);
    assign time_ok = (param_wr_data >= TIME_MIN) && (param_wr_data <= TIME_MAX);
    assign pct_ok  = param_wr_data <= PCT_MAX;
    assign mode_ok = param_wr_data <= MODE_TWO;

    // out-of-range data is dropped rather than clipped, so a bad write is visible
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            traverse_mode_select   <= MODE_RST;
            amplitude_percent      <= AMP_RST;
            down_turn_compensation <= DCOMP_RST;
            up_turn_compensation   <= UCOMP_RST;
            traverse_accel_time    <= TIME_RST;
            traverse_decel_time    <= TIME_RST;
        end else if (open_wr) begin
            if (param_wr_idx == PIDX_MODE && mode_ok) begin
                traverse_mode_select <= param_wr_data;
            end else if (param_wr_idx == PIDX_AMP && pct_ok) begin
                amplitude_percent <= param_wr_data;
            end else if (param_wr_idx == PIDX_DCOMP && pct_ok) begin
                down_turn_compensation <= param_wr_data;
            end else if (param_wr_idx == PIDX_UCOMP && pct_ok) begin
                up_turn_compensation <= param_wr_data;
            end else if (param_wr_idx == PIDX_TACC && time_ok) begin
                traverse_accel_time <= param_wr_data;
            end else if (param_wr_idx == PIDX_TDEC && time_ok) begin
                traverse_decel_time <= param_wr_data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            param_wr_refused <= 1'b0;
        end else begin
            param_wr_refused <= param_wr_en && !open_wr;
        end
    end

    AST_PARAM_LOCK: assert property (@(posedge core_clk) disable iff (!nrst)
        (extended_param_visibility != VIS_OPEN) |=>
            $stable(amplitude_percent) && $stable(traverse_accel_time)
            && $stable(traverse_mode_select))
        else $error("parameter changed while locked");

    AST_TIME_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
        traverse_accel_time >= TIME_MIN && traverse_accel_time <= TIME_MAX
        && traverse_decel_time >= TIME_MIN && traverse_decel_time <= TIME_MAX)
        else $error("traverse ramp time out of range");

endmodule
`default_nettype wire

/* hw/tfp_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Traverse up-ramp time defaults to 5 s, accepts 0.1 to 3600 s.
// - Traverse down-ramp time defaults to 5 s, accepts 0.1 to 3600 s.
// - Pattern runs only with mode 1 or 2 and the enable asserted.
// - Terminal selector code 37 routes that terminal to the enable.
// - No terminal assigned: enable counts as always on.
// - Amplitude is base times amplitude percent over 100.
// - Downturn step is amplitude times down compensation over 100.
// - Upturn step is amplitude times up compensation over 100.
// - Start input ramps output to base at normal acceleration time.
// - At base with enable on, ramp to base plus amplitude at traverse rate.
// - At top, drop by downturn step, then ramp to base minus amplitude.
// - At bottom, rise by upturn step, ramp to top again; repeat.
// - Enable off during traverse: return to base at normal times.
// - Start removed: ramp to zero at normal deceleration time.
// - Traverse parameters writable only while visibility setting is 0.
// - Pattern output is clamped to the max and min frequency limits.
// - Base, amplitude or compensation change: reach old base, then use new values.
// - Stall halts traverse; return to base at normal times, then resume.
// - Traverse ramps are linear; no S-curve shaping applied.
module tfp_core
    import tfp_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        forward_start,
    input  wire logic        reverse_start,
    input  wire logic [NUM_TERMS-1:0] term_in,
    input  wire logic [7:0]  input_terminal_function [NUM_TERMS],
    input  wire logic [15:0] base_frequency,
    input  wire logic [15:0] max_frequency,
    input  wire logic [15:0] min_frequency,
    input  wire logic [15:0] normal_accel_time,
    input  wire logic [15:0] normal_decel_time,
    input  wire logic        stall_active,
    input  wire logic [7:0]  extended_param_visibility,
    input  wire logic        param_wr_en,
    input  wire logic [2:0]  param_wr_idx,
    input  wire logic [15:0] param_wr_data,
    output logic             param_wr_refused,
    output logic [15:0]      out_frequency,
    output logic             out_reverse,
    output logic             pattern_rising,
    output logic             traverse_running
);

    function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] p);
        logic [31:0] prod;
        prod = 32'(v) * 32'(p);
        pct_of = 16'(prod / PCT_DIV);
    endfunction

    // fractional step per tick; never zero so every ramp terminates
    function automatic logic [31:0] ramp_step(input logic [15:0] span,
                                              input logic [15:0] time_ds);
        logic [31:0] ticks;
        logic [31:0] q;
        ticks = 32'(time_ds) * 32'(TICKS_PER_DS);
        if (ticks == 32'h0) begin
            ticks = 32'h1;
        end
        q = {span, 16'h0000} / ticks;
        ramp_step = (q == 32'h0) ? 32'h1 : q;
    endfunction

    function automatic logic [31:0] ramp_to(input logic [31:0] cur,
                                            input logic [31:0] tgt,
                                            input logic [31:0] stp);
        ramp_to = tgt;
        if (cur < tgt && (tgt - cur) > stp) begin
            ramp_to = cur + stp;
        end else if (cur > tgt && (cur - tgt) > stp) begin
            ramp_to = cur - stp;
        end
    endfunction

    logic [15:0] traverse_mode_select;
    logic [15:0] amplitude_percent;
    logic [15:0] down_turn_compensation;
    logic [15:0] up_turn_compensation;
    logic [15:0] traverse_accel_time;
    logic [15:0] traverse_decel_time;

    tfp_param_store u_store (
        .core_clk                  (core_clk),
        .nrst                      (nrst),
        .extended_param_visibility (extended_param_visibility),
        .param_wr_en               (param_wr_en),
        .param_wr_idx              (param_wr_idx),
        .param_wr_data             (param_wr_data),
        .param_wr_refused          (param_wr_refused),
        .traverse_mode_select      (traverse_mode_select),
        .amplitude_percent         (amplitude_percent),
        .down_turn_compensation    (down_turn_compensation),
        .up_turn_compensation      (up_turn_compensation),
        .traverse_accel_time       (traverse_accel_time),
        .traverse_decel_time       (traverse_decel_time)
    );

    tfp_state_t  state;
    tfp_state_t  next_state;
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic        next_rising;
    logic        load_snap;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        traverse_enable_input;
    logic        trav_active;
    logic        start_any;
    logic [15:0] amplitude_frequency;
    logic [15:0] downturn_step;
    logic [15:0] upturn_step;
    logic [15:0] snap_base;
    logic [15:0] snap_amp;
    logic [15:0] snap_dstep;
    logic [15:0] snap_ustep;
    logic        changed;
    logic [16:0] hi_sum;
    logic [15:0] hi_f;
    logic [15:0] lo_f;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic [31:0] base_q;
    logic [31:0] snapb_q;
    logic [31:0] up_step;
    logic [31:0] dn_step;
    logic [31:0] norm_step;
    logic [31:0] dec_step;

    // enable routing across the input terminals
    always_comb begin
        logic any_assigned;
        logic any_on;
        any_assigned = 1'b0;
        any_on       = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            if (input_terminal_function[i] == FUNC_TRAVERSE_EN) begin
                any_assigned = 1'b1;
                any_on       = any_on | term_in[i];
            end
        end
        traverse_enable_input = any_assigned ? any_on : 1'b1;
    end

    assign trav_active = (traverse_mode_select == MODE_ONE
                          || traverse_mode_select == MODE_TWO)
                         && traverse_enable_input;
    assign start_any   = forward_start || reverse_start;

    assign amplitude_frequency = pct_of(base_frequency, amplitude_percent);
    assign downturn_step       = pct_of(amplitude_frequency, down_turn_compensation);
    assign upturn_step         = pct_of(amplitude_frequency, up_turn_compensation);
    assign changed = snap_base != base_frequency || snap_amp != amplitude_frequency
                     || snap_dstep != downturn_step || snap_ustep != upturn_step;

    assign hi_sum  = {1'b0, snap_base} + {1'b0, snap_amp};
    assign hi_f    = hi_sum[16] ? 16'hffff : hi_sum[15:0];
    assign lo_f    = (snap_base > snap_amp) ? snap_base - snap_amp : 16'h0000;
    assign hi_q    = {hi_f, 16'h0000};
    assign lo_q    = {lo_f, 16'h0000};
    assign base_q  = {base_frequency, 16'h0000};
    assign snapb_q = {snap_base, 16'h0000};

    // linear traverse slope over the full 2*amplitude span
    assign up_step   = ramp_step({snap_amp[14:0], 1'b0}, traverse_accel_time);
    assign dn_step   = ramp_step({snap_amp[14:0], 1'b0}, traverse_decel_time);
    assign norm_step = (acc < base_q) ? ramp_step(max_frequency, normal_accel_time)
                                      : ramp_step(max_frequency, normal_decel_time);
    assign dec_step  = ramp_step(max_frequency, normal_decel_time);

    always_comb begin
        next_state  = state;
        next_acc    = acc;
        next_rising = pattern_rising;
        load_snap   = 1'b0;
        case (state)
            S_IDLE: begin
                if (start_any) begin
                    next_state = S_APPROACH;
                end
            end
            S_APPROACH: begin
                // frequency is held while stall prevention acts
                if (!stall_active) begin
                    if (acc == base_q) begin
                        next_state = S_BASE;
                    end else if (tick) begin
                        next_acc = ramp_to(acc, base_q, norm_step);
                    end
                end
            end
            S_BASE: begin
                load_snap = 1'b1;
                if (acc != base_q) begin
                    next_state = S_APPROACH;
                end else if (trav_active && !stall_active) begin
                    next_state  = S_UP;
                    next_rising = 1'b1;
                end
            end
            S_UP, S_DOWN: begin
                if (!trav_active || stall_active) begin
                    next_state = S_APPROACH;
                end else if (changed) begin
                    next_state = S_RECENTER;
                end else if (tick && state == S_UP) begin
                    if (acc >= hi_q) begin
                        next_acc    = (hi_f > snap_dstep) ? {hi_f - snap_dstep, 16'h0000}
                                                          : 32'h0;
                        next_state  = S_DOWN;
                        next_rising = 1'b0;
                    end else begin
                        next_acc = ramp_to(acc, hi_q, up_step);
                    end
                end else if (tick) begin
                    if (acc <= lo_q) begin
                        next_acc    = {lo_f + snap_ustep, 16'h0000};
                        next_state  = S_UP;
                        next_rising = 1'b1;
                    end else begin
                        next_acc = ramp_to(acc, lo_q, dn_step);
                    end
                end
            end
            S_RECENTER: begin
                if (!trav_active || stall_active) begin
                    next_state = S_APPROACH;
                end else if (acc == snapb_q) begin
                    load_snap   = 1'b1;
                    next_state  = S_UP;
                    next_rising = 1'b1;
                end else if (tick) begin
                    next_acc = ramp_to(acc, snapb_q, (acc < snapb_q) ? up_step : dn_step);
                end
            end
            S_STOP: begin
                if (start_any) begin
                    next_state = S_APPROACH;
                end else if (acc == 32'h0) begin
                    next_state = S_IDLE;
                end else if (tick) begin
                    next_acc = ramp_to(acc, 32'h0, dec_step);
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (!start_any && state != S_IDLE && state != S_STOP) begin
            next_state = S_STOP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else if (tick_cnt >= 32'(TICK_CYC - 1)) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state          <= S_IDLE;
            acc            <= 32'h0;
            pattern_rising <= 1'b1;
        end else begin
            state          <= next_state;
            acc            <= next_acc;
            pattern_rising <= next_rising;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            snap_base  <= 16'h0000;
            snap_amp   <= 16'h0000;
            snap_dstep <= 16'h0000;
            snap_ustep <= 16'h0000;
        end else if (load_snap) begin
            snap_base  <= base_frequency;
            snap_amp   <= amplitude_frequency;
            snap_dstep <= downturn_step;
            snap_ustep <= upturn_step;
        end
    end

    // min clamp only inside the pattern; a stop must still reach zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            out_frequency <= 16'h0000;
        end else if (next_state == S_IDLE) begin
            out_frequency <= 16'h0000;
        end else if (next_acc[31:FRAC_BITS] > max_frequency) begin
            out_frequency <= max_frequency;
        end else if ((next_state == S_UP || next_state == S_DOWN || next_state == S_RECENTER)
                     && next_acc[31:FRAC_BITS] < min_frequency) begin
            out_frequency <= min_frequency;
        end else begin
            out_frequency <= next_acc[31:FRAC_BITS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            out_reverse <= 1'b0;
        end else if (state == S_IDLE && start_any) begin
            out_reverse <= reverse_start && !forward_start;
        end
    end

    assign traverse_running = (state == S_UP) || (state == S_DOWN) || (state == S_RECENTER);

    AST_IDLE_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_IDLE) && $past(state == S_IDLE) |-> out_frequency == 16'h0000)
        else $error("output not zero in idle");

    AST_ENABLE_DEFAULT: assert property (@(posedge core_clk) disable iff (!nrst)
        (input_terminal_function[0] != FUNC_TRAVERSE_EN
         && input_terminal_function[1] != FUNC_TRAVERSE_EN
         && input_terminal_function[2] != FUNC_TRAVERSE_EN
         && input_terminal_function[3] != FUNC_TRAVERSE_EN
         && input_terminal_function[4] != FUNC_TRAVERSE_EN) |-> traverse_enable_input)
        else $error("traverse enable not forced on");

    AST_ENABLE_ROUTE: assert property (@(posedge core_clk) disable iff (!nrst)
        input_terminal_function[2] == FUNC_TRAVERSE_EN && (term_in == 5'h00 || term_in[2])
        |-> traverse_enable_input == term_in[2])
        else $error("traverse enable routing wrong");

    AST_TRAV_NEEDS_MODE: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_BASE) && !trav_active && start_any |=> state != S_UP)
        else $error("traverse started without mode and enable");

    AST_LEAVE_ON_DISABLE: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_UP || state == S_DOWN) && start_any
        && (!trav_active || stall_active) |=> state == S_APPROACH)
        else $error("pattern not abandoned on disable or stall");

    AST_STOP_ON_START_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        (state != S_IDLE) && !start_any |=> (state == S_STOP || state == S_IDLE))
        else $error("start removal did not stop");

    AST_DOWNTURN: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_UP) && tick && trav_active && !stall_active && !changed && start_any
        && acc >= hi_q && hi_f > snap_dstep
        |=> state == S_DOWN && acc == {$past(hi_f) - $past(snap_dstep), 16'h0000})
        else $error("downturn compensation wrong");

    AST_UPTURN: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_DOWN) && tick && trav_active && !stall_active && !changed && start_any
        && acc <= lo_q |=> state == S_UP && acc == {$past(lo_f) + $past(snap_ustep), 16'h0000})
        else $error("upturn compensation wrong");

    AST_CLAMP: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == S_UP || state == S_DOWN) && $past(state == S_UP || state == S_DOWN)
        && min_frequency <= max_frequency && $stable(min_frequency) && $stable(max_frequency)
        |-> out_frequency <= max_frequency && out_frequency >= min_frequency)
        else $error("pattern output outside limits");

    AST_TRAV_FROM_BASE: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(state == S_UP) && $past(state == S_BASE) |-> acc == {snap_base, 16'h0000})
        else $error("traverse began away from base");

    COV_FULL_CYCLE: cover property (@(posedge core_clk) disable iff (!nrst)
        state == S_DOWN ##1 state == S_UP);
    COV_RECENTER: cover property (@(posedge core_clk) disable iff (!nrst)
        state == S_RECENTER ##1 state == S_UP);
    COV_STOP: cover property (@(posedge core_clk) disable iff (!nrst)
        state == S_STOP ##1 state == S_IDLE);

endmodule
`default_nettype wire

/* tb/tfp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tfp_ctrl_model (
    input  wire logic  core_clk,
    input  wire logic  run,
    input  wire logic  rev,
    input  wire logic  en,
    output logic       forward_start,
    output logic       reverse_start,
    output logic [4:0] term_in
);
    // levels only move after an edge, like relay contacts
    always @(posedge core_clk) begin
        forward_start <= run & ~rev;
        reverse_start <= run & rev;
        term_in <= {2'h0, en, 2'h0};
    end
endmodule
`default_nettype wire

/* tb/tb_traverse_frequency_pattern.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_traverse_frequency_pattern;
    import tfp_pkg::*;
    logic        core_clk, nrst, run, rev, en, fwd, rvs, stall_active, param_wr_en;
    logic        param_wr_refused, out_reverse, pattern_rising, traverse_running;
    logic [4:0]  term_in;
    logic [7:0]  term_fn [NUM_TERMS];
    logic [7:0]  vis;
    logic [2:0]  param_wr_idx;
    logic [15:0] param_wr_data, base, fmax, fmin, nacc, ndec, out_frequency;
    int          error_cnt, n_tests, cyc;

    tfp_ctrl_model ctrl (.core_clk(core_clk), .run(run), .rev(rev), .en(en),
        .forward_start(fwd), .reverse_start(rvs), .term_in(term_in));
    // short tick keeps whole pattern cycles inside a few thousand clocks
    tfp_core #(.TICK_CYC(10)) dut (.core_clk(core_clk), .nrst(nrst), .forward_start(fwd),
        .reverse_start(rvs), .term_in(term_in), .input_terminal_function(term_fn),
        .base_frequency(base), .max_frequency(fmax), .min_frequency(fmin),
        .normal_accel_time(nacc), .normal_decel_time(ndec), .stall_active(stall_active),
        .extended_param_visibility(vis), .param_wr_en(param_wr_en),
        .param_wr_idx(param_wr_idx), .param_wr_data(param_wr_data),
        .param_wr_refused(param_wr_refused), .out_frequency(out_frequency),
        .out_reverse(out_reverse), .pattern_rising(pattern_rising),
        .traverse_running(traverse_running));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(posedge core_clk);
        param_wr_en <= 1'b1;
        param_wr_idx <= idx;
        param_wr_data <= d;
        @(posedge core_clk);
        param_wr_en <= 1'b0;
        #1;
    endtask
    // bounded wait: 0 running flag, 1 direction flag, else output frequency
    task automatic wait_until(input int sel, input logic [15:0] v);
        int n;
        n = 0;
        while (n < 4000 && (sel == 0 ? {15'h0, traverse_running} :
               sel == 1 ? {15'h0, pattern_rising} : out_frequency) !== v) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_reset();
        chk("out_frequency", 16'h0000, out_frequency);
        chk("pattern_rising", 16'h0001, {15'h0, pattern_rising});
        chk("traverse_running", 16'h0000, {15'h0, traverse_running});
    endtask
    task automatic t_refuse();
        vis <= 8'h01;
        wr(PIDX_MODE, MODE_ONE);
        chk("param_wr_refused", 16'h0001, {15'h0, param_wr_refused});
        vis <= 8'h00;
    endtask
    task automatic t_pattern();
        wr(PIDX_MODE, MODE_TWO);
        wr(PIDX_TACC, TIME_MIN);
        wr(PIDX_TDEC, TIME_MIN);
        run <= 1'b1;
        wait_until(0, 16'h0001);
        chk("traverse_running", 16'h0001, {15'h0, traverse_running});
        chk("out_reverse", 16'h0000, {15'h0, out_reverse});
        chk("out_frequency", base, out_frequency);
        wait_until(1, 16'h0000);
        chk("out_frequency", 16'd1090, out_frequency);
        wait_until(1, 16'h0001);
        chk("out_frequency", 16'd910, out_frequency);
    endtask
    task automatic t_enable();
        term_fn[2] <= FUNC_TRAVERSE_EN; // enable routed but held off
        wait_until(0, 16'h0000);
        chk("traverse_running", 16'h0000, {15'h0, traverse_running});
        wait_until(2, base);
        chk("out_frequency", base, out_frequency);
        en <= 1'b1;
        wait_until(0, 16'h0001);
        chk("traverse_running", 16'h0001, {15'h0, traverse_running});
    endtask
    // clamp while rising, stall hold and release, then base moved mid-pattern
    task automatic t_limits();
        fmax <= 16'd1050;
        wait_until(2, 16'd1050);
        repeat (100) @(posedge core_clk);
        #1;
        chk("out_frequency", 16'd1050, out_frequency);
        {stall_active, fmax} <= {1'b1, 16'd2000};
        repeat (30) @(posedge core_clk);
        #1;
        chk("traverse_running", 16'h0000, {15'h0, traverse_running});
        stall_active <= 1'b0;
        wait_until(0, 16'h0001);
        chk("out_frequency", base, out_frequency);
        base <= 16'd1020;
        wait_until(1, 16'h0000);
        chk("out_frequency", 16'd1112, out_frequency);
    endtask
    task automatic t_reverse();
        {rev, run} <= 2'b11;
        repeat (4) @(posedge core_clk);
        #1;
        chk("out_reverse", 16'h0001, {15'h0, out_reverse});
        run <= 1'b0;
        wait_until(2, 16'h0000);
        chk("out_frequency", 16'h0000, out_frequency);
    endtask
    task automatic t_stop();
        run <= 1'b0;
        wait_until(2, 16'h0000);
        chk("out_frequency", 16'h0000, out_frequency);
        chk("traverse_running", 16'h0000, {15'h0, traverse_running});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // 20000 cycles is about five times the full sequence
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        {nrst, run, rev, en, stall_active, param_wr_en} = 6'h00;
        for (int i = 0; i < NUM_TERMS; i++)
            term_fn[i] = 8'h00;
        {vis, param_wr_idx, param_wr_data} = 27'h0;
        {base, fmax, fmin, nacc, ndec} = {16'd1000, 16'd2000, 16'd0, 16'd1, 16'd1};
        {error_cnt, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        t_refuse();
        t_pattern();
        t_enable();
        t_limits();
        t_stop();
        t_reverse();
        wrap_up();
    end
endmodule
`default_nettype wire
